/* pkg/ufp_pkg.sv */
/*
  Package for the frame and transceiver register slice of the USB interface unit.
  Holds offsets, field positions, reset values and the carrier structs.
  Assumes a single 40 MHz clock and a synchronous active-low reset.
*/
package ufp_pkg;

  localparam logic [7:0] UFP_OFF_SOF = 8'h28;
  localparam logic [7:0] UFP_OFF_PID = 8'h2C;
  localparam logic [7:0] UFP_OFF_EP = 8'h30;
  localparam logic [7:0] UFP_OFF_EP_MARK = 8'h34;
  localparam logic [7:0] UFP_OFF_OTG_MASK = 8'h38;
  localparam logic [7:0] UFP_OFF_PWR_SIG = 8'h3C;
  localparam logic [7:0] UFP_OFF_XCVR_CTRL = 8'h40;
  localparam logic [7:0] UFP_OFF_IRQ_STATUS = 8'h44;
  localparam logic [7:0] UFP_OFF_IRQ_MASK = 8'h48;

  localparam int UFP_SOF_HI_MSB = 10;
  localparam int UFP_SOF_HI_LSB = 8;
  localparam int UFP_EP_VALID_BIT = 4;
  localparam int UFP_PWR_VALID_BIT = 8;
  localparam int UFP_XC_PULLDOWN_OFF_BIT = 18;
  localparam int UFP_XC_SE0_RESUME_BIT = 13;
  localparam int UFP_XC_K_RESUME_BIT = 12;
  localparam int UFP_XC_FILT_MSB = 11;
  localparam int UFP_XC_FILT_LSB = 8;
  localparam int UFP_XC_SUSP_CTRL_BIT = 7;
  localparam int UFP_XC_CONF_MSB = 6;
  localparam int UFP_XC_CONF_LSB = 4;

  localparam logic [7:0] UFP_EP_MARK_OR = 8'h10;
  localparam logic [31:0] UFP_RST_ZERO = 32'h0000_0000;

  // Interrupt status / mask bit positions
  localparam int UFP_IRQ_PKT = 0;
  localparam int UFP_IRQ_SE0_RESUME = 1;
  localparam int UFP_IRQ_K_RESUME = 2;
  localparam int UFP_IRQ_LINE_CHANGE = 3;
  localparam int UFP_IRQ_W = 4;

  // Linestate codes
  localparam logic [1:0] UFP_LS_SE0 = 2'h0;
  localparam logic [1:0] UFP_LS_K = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ufp_bus_req_s;

  typedef struct packed {
    logic valid;
    logic [3:0] pid;
    logic [3:0] ep;
    logic ep_valid;
  } ufp_rx_pkt_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufp_rx_port_s;

  typedef struct packed {
    logic pulldown_off;
    logic se0_resume;
    logic k_resume;
    logic [3:0] filt_log2;
    logic susp_ctrl;
    logic [2:0] conf;
  } ufp_xcvr_ctrl_s;

endpackage

/* hw/ufp_line_filter.sv */
/*
  Linestate filter: a change on the raw linestate is passed on only after it
  has stood still for two to the power of the setting, in clocks.
  Assumes the raw linestate is already synchronised to i_sys_clk.
*/
`timescale 1ns/10ps
module ufp_line_filter
  import ufp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic [3:0] i_log2,
  input wire logic [1:0] i_line,
  // Filtered result
  output logic [1:0] o_line,
  output logic o_change
);

  initial begin
    if (CNT_W < 16) begin
      $error("CNT_W must hold two to the fifteenth");
    end
  end

  typedef struct packed {
    logic [1:0] cand;
    logic [CNT_W-1:0] cnt;
    logic [1:0] out;
    logic chg;
  } ufp_filt_state_s;

  ufp_filt_state_s st;
  ufp_filt_state_s next_st;
  logic [CNT_W-1:0] target;

  always_comb begin
    target = CNT_W'(1) << i_log2;
    next_st = st;
    next_st.chg = 1'b0;
    if (i_line != st.cand) begin
      next_st.cand = i_line;
      next_st.cnt = CNT_W'(1);
    end else if (st.cand != st.out) begin
      // Zero setting gives a one-clock delay  see [R12]
      if (st.cnt >= target) begin // see [R09]
        next_st.out = st.cand;
        next_st.chg = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_line = st.out;
  assign o_change = st.chg;

  filt_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R09]
    (st.cand != st.out && st.cnt < target && i_line == st.cand) |=> !o_change)
    else $error("filter passed change early");

endmodule

/* hw/ufp_frame_regs.sv */
/*
  Frame, packet and transceiver control registers of the USB interface unit.
  Assumes a plain register port with read data one cycle after the read
  strobe, a packet-capture pulse from the receive logic, and a raw linestate
  arriving from the transceiver clock domain.
*/
// Local design decision: the strobed register port.
// Functional notes
// [R01] The 11-bit start-of-frame counter is readable and writable, high bits 10:8, low 7:0.
// [R02] The PID of the last received packet is captured read-only in bits 3:0.
// [R03] The endpoint of the last received packet is held read-only in bits 3:0.
// [R04] Bit 4 of the endpoint register reads one when the endpoint field is valid, zero at reset.
// [R05] A 16-bit mask marks endpoints; a marked endpoint appears ORed with 0x10 on the receive port.
// [R06] Bit 18 of transceiver control disables pulldowns on both eight-bit ports.
// [R07] Bit 13 is set after an SE0 auto-resume and stays set until software writes zero.
// [R08] Bit 12 is set after a K auto-resume and stays set until software writes zero.
// [R09] Linestate changes are delayed by two to the power of bits 11:8 clocks.
// [R10] With bit 7 set the suspend controller resumes by itself, else software polls linestate.
// [R11] Bits 6:4 drive the three transceiver configuration pins directly.
// [R12] Reserved bits read zero and ignore writes; a zero filter setting delays one clock.
`timescale 1ns/10ps
module ufp_frame_regs
  import ufp_pkg::*;
#(
  parameter int EP_NUM = 16
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Received packet capture
  input wire ufp_rx_pkt_s i_rx_pkt,
  output ufp_rx_port_s o_rx_port,
  // Transceiver side
  input wire logic [1:0] i_linestate,
  input wire logic i_suspended,
  output logic [1:0] o_linestate_filt,
  output logic o_resume_req,
  output logic [2:0] o_xcvr_conf,
  output logic o_pulldown_off,
  // Other register values
  output logic [31:0] o_otg_mask,
  output logic [8:0] o_pwr_sig,
  output logic o_irq
);

  initial begin
    if (EP_NUM != 16) begin
      $error("EP_NUM must be 16");
    end
  end

  typedef struct packed {
    logic [10:0] sof;
    logic [3:0] pid;
    logic [3:0] ep;
    logic ep_valid;
    logic [15:0] ep_mark;
    logic [31:0] otg_mask;
    logic [8:0] pwr_sig;
    ufp_xcvr_ctrl_s xc;
    logic [UFP_IRQ_W-1:0] irq_stat;
    logic [UFP_IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    ufp_rx_port_s rx_port;
    logic resume_req;
    logic irq;
    logic [1:0] ls_q1;
    logic [1:0] ls_q2;
    logic [1:0] ls_q3;
    logic [1:0] ls_sync;
  } ufp_regs_state_s;

  ufp_regs_state_s st;
  ufp_regs_state_s next_st;
  logic [1:0] filt_line;
  logic filt_change;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ufp_line_filter #(
    .CNT_W(16)
  ) u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_log2(st.xc.filt_log2),
    .i_line(st.ls_sync),
    .o_line(filt_line),
    .o_change(filt_change)
  );

  always_comb begin
    logic resume_evt;
    logic [UFP_IRQ_W-1:0] evt;
    resume_evt = 1'b0;
    evt = '0;
    next_st = st;

    // Three-stage sync; a change counts once stages two and three agree
    next_st.ls_q1 = i_linestate;
    next_st.ls_q2 = st.ls_q1;
    next_st.ls_q3 = st.ls_q2;
    if (st.ls_q2 == st.ls_q3) begin
      next_st.ls_sync = st.ls_q3;
    end

    next_st.rx_port.valid = 1'b0;
    if (i_rx_pkt.valid) begin
      next_st.pid = i_rx_pkt.pid; // see [R02]
      next_st.ep = i_rx_pkt.ep; // see [R03]
      next_st.ep_valid = i_rx_pkt.ep_valid; // see [R04]
      next_st.rx_port.valid = i_rx_pkt.ep_valid;
      next_st.rx_port.data = {4'h0, i_rx_pkt.ep};
      if (st.ep_mark[i_rx_pkt.ep]) begin
        next_st.rx_port.data = {4'h0, i_rx_pkt.ep} | UFP_EP_MARK_OR; // see [R05]
      end
      evt[UFP_IRQ_PKT] = 1'b1;
    end

    // Writes; reserved bits are dropped here  see [R12]
    if (i_wr) begin
      if (hit(i_addr, UFP_OFF_SOF)) begin
        next_st.sof = i_wdata[10:0]; // see [R01]
      end else if (hit(i_addr, UFP_OFF_EP_MARK)) begin
        next_st.ep_mark = i_wdata[15:0]; // see [R05]
      end else if (hit(i_addr, UFP_OFF_OTG_MASK)) begin
        next_st.otg_mask = i_wdata;
      end else if (hit(i_addr, UFP_OFF_PWR_SIG)) begin
        next_st.pwr_sig = i_wdata[8:0];
      end else if (hit(i_addr, UFP_OFF_XCVR_CTRL)) begin
        next_st.xc.pulldown_off = i_wdata[UFP_XC_PULLDOWN_OFF_BIT]; // see [R06]
        // Only a zero clears; writing one leaves the flag as it is
        if (!i_wdata[UFP_XC_SE0_RESUME_BIT]) begin
          next_st.xc.se0_resume = 1'b0; // see [R07]
        end
        if (!i_wdata[UFP_XC_K_RESUME_BIT]) begin
          next_st.xc.k_resume = 1'b0; // see [R08]
        end
        next_st.xc.filt_log2 = i_wdata[UFP_XC_FILT_MSB:UFP_XC_FILT_LSB]; // see [R09]
        next_st.xc.susp_ctrl = i_wdata[UFP_XC_SUSP_CTRL_BIT]; // see [R10]
        next_st.xc.conf = i_wdata[UFP_XC_CONF_MSB:UFP_XC_CONF_LSB]; // see [R11]
      end else if (hit(i_addr, UFP_OFF_IRQ_MASK)) begin
        next_st.irq_mask = i_wdata[UFP_IRQ_W-1:0];
      end
    end

    // Auto-resume; set after clear so an event in a clearing cycle survives
    next_st.resume_req = 1'b0;
    if (st.xc.susp_ctrl && i_suspended && filt_change) begin // see [R10]
      resume_evt = 1'b1;
      next_st.resume_req = 1'b1;
      if (filt_line == UFP_LS_SE0) begin
        next_st.xc.se0_resume = 1'b1; // see [R07]
        evt[UFP_IRQ_SE0_RESUME] = 1'b1;
      end else if (filt_line == UFP_LS_K) begin
        next_st.xc.k_resume = 1'b1; // see [R08]
        evt[UFP_IRQ_K_RESUME] = 1'b1;
      end else begin
        resume_evt = 1'b0;
        next_st.resume_req = 1'b0;
      end
    end
    if (filt_change) begin
      evt[UFP_IRQ_LINE_CHANGE] = 1'b1;
    end

    // Read data one cycle later; unmapped reads give zero  see [R12]
    next_st.rdata = UFP_RST_ZERO;
    if (i_rd) begin
      if (hit(i_addr, UFP_OFF_SOF)) begin
        next_st.rdata = {21'h0, st.sof}; // see [R01]
      end else if (hit(i_addr, UFP_OFF_PID)) begin
        next_st.rdata = {28'h0, st.pid}; // see [R02]
      end else if (hit(i_addr, UFP_OFF_EP)) begin
        next_st.rdata = {27'h0, st.ep_valid, st.ep}; // see [R03]
      end else if (hit(i_addr, UFP_OFF_EP_MARK)) begin
        next_st.rdata = {16'h0, st.ep_mark};
      end else if (hit(i_addr, UFP_OFF_OTG_MASK)) begin
        next_st.rdata = st.otg_mask;
      end else if (hit(i_addr, UFP_OFF_PWR_SIG)) begin
        next_st.rdata = {23'h0, st.pwr_sig};
      end else if (hit(i_addr, UFP_OFF_XCVR_CTRL)) begin
        next_st.rdata = {13'h0, st.xc.pulldown_off, 4'h0, st.xc.se0_resume,
                         st.xc.k_resume, st.xc.filt_log2, st.xc.susp_ctrl,
                         st.xc.conf, 4'h0};
      end else if (hit(i_addr, UFP_OFF_IRQ_STATUS)) begin
        next_st.rdata = {28'h0, st.irq_stat};
      end else if (hit(i_addr, UFP_OFF_IRQ_MASK)) begin
        next_st.rdata = {28'h0, st.irq_mask};
      end
    end

    // Read clears status, but a same-cycle event stays set
    if (i_rd && hit(i_addr, UFP_OFF_IRQ_STATUS)) begin
      next_st.irq_stat = evt;
    end else begin
      next_st.irq_stat = st.irq_stat | evt;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    if (resume_evt) begin
      next_st.resume_req = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_rx_port = st.rx_port;
  assign o_linestate_filt = filt_line;
  assign o_resume_req = st.resume_req;
  assign o_xcvr_conf = st.xc.conf; // see [R11]
  assign o_pulldown_off = st.xc.pulldown_off; // see [R06]
  assign o_otg_mask = st.otg_mask;
  assign o_pwr_sig = st.pwr_sig;
  assign o_irq = st.irq;

  sof_readback_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R01]
    (i_wr && i_addr == UFP_OFF_SOF) ##1 (!i_wr && !i_rd) ##1 (i_rd && i_addr == UFP_OFF_SOF)
      |=> o_rdata == {21'h0, $past(i_wdata[10:0], 3)})
    else $error("sof readback wrong");

  pid_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R02]
    i_rx_pkt.valid |=> st.pid == $past(i_rx_pkt.pid))
    else $error("pid not captured");

  ep_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R03]
    i_rx_pkt.valid |=> st.ep == $past(i_rx_pkt.ep) && st.ep_valid == $past(i_rx_pkt.ep_valid))
    else $error("endpoint not captured");

  ep_mark_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R05]
    (i_rx_pkt.valid && i_rx_pkt.ep_valid && st.ep_mark[i_rx_pkt.ep] && !i_wr)
      |=> o_rx_port.valid && o_rx_port.data[4] && o_rx_port.data[3:0] == $past(i_rx_pkt.ep))
    else $error("marked endpoint not flagged");

  pulldown_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R06]
    (i_wr && i_addr == UFP_OFF_XCVR_CTRL)
      |=> o_pulldown_off == $past(i_wdata[UFP_XC_PULLDOWN_OFF_BIT]))
    else $error("pulldown control lost");

  se0_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R07]
    (st.xc.se0_resume && !(i_wr && i_addr == UFP_OFF_XCVR_CTRL)) |=> st.xc.se0_resume)
    else $error("se0 resume flag dropped");

  k_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R08]
    (st.xc.k_resume && !(i_wr && i_addr == UFP_OFF_XCVR_CTRL)) |=> st.xc.k_resume)
    else $error("k resume flag dropped");

  no_auto_resume_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R10]
    !st.xc.susp_ctrl |=> !o_resume_req)
    else $error("resume without suspend control");

  conf_pins_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R11]
    (i_wr && i_addr == UFP_OFF_XCVR_CTRL)
      |=> o_xcvr_conf == $past(i_wdata[UFP_XC_CONF_MSB:UFP_XC_CONF_LSB]))
    else $error("conf pins wrong");

  // Read data stand one cycle only, so an idle port must read back zero
  rdata_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_rd |=> o_rdata == UFP_RST_ZERO)
    else $error("read data not cleared");

  xc_rsvd_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R12]
    (i_rd && i_addr == UFP_OFF_XCVR_CTRL)
      |=> o_rdata[31:19] == 13'h0 && o_rdata[17:14] == 4'h0 && o_rdata[3:0] == 4'h0)
    else $error("control reserved bits set");

  ep_rsvd_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R12]
    (i_rd && i_addr == UFP_OFF_EP) |=> o_rdata[31:5] == 27'h0)
    else $error("endpoint reserved bits set");

  rx_valid_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R05]
    !(i_rx_pkt.valid && i_rx_pkt.ep_valid) |=> !o_rx_port.valid)
    else $error("receive port valid without endpoint");

  // Interrupt is a level, raised the cycle after the event
  pkt_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_rx_pkt.valid && st.irq_mask[UFP_IRQ_PKT] && !i_wr) |=> o_irq)
    else $error("packet interrupt missing");

  stat_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == UFP_OFF_IRQ_STATUS && !i_rx_pkt.valid && !filt_change)
      |=> st.irq_stat == '0)
    else $error("status not cleared by read");

  // Set must win over a clearing write in the same cycle
  se0_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R07]
    (st.xc.susp_ctrl && i_suspended && filt_change && filt_line == UFP_LS_SE0)
      |=> st.xc.se0_resume && o_resume_req)
    else $error("se0 resume flag not set");

  k_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see [R08]
    (st.xc.susp_ctrl && i_suspended && filt_change && filt_line == UFP_LS_K)
      |=> st.xc.k_resume && o_resume_req)
    else $error("k resume flag not set");

endmodule

/* verif/ufp_host_model.sv */
/*
  Host-side model: raw linestate and received-packet capture pulses.
  Assumes the bench calls its tasks from the i_sys_clk domain.
*/
`timescale 1ns/10ps
module ufp_host_model
  import ufp_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Toward the block
  output logic [1:0] o_linestate,
  output ufp_rx_pkt_s o_rx_pkt
);
  initial begin
    o_linestate = 2'h1;
    o_rx_pkt = '0;
  end
  task automatic set_line(input logic [1:0] ls);
    @(posedge i_sys_clk);
    o_linestate <= ls;
  endtask
  // Fields are inverted once the pulse ends, so a stale capture is seen
  task automatic send_pkt(input logic [3:0] p, input logic [3:0] e, input logic v);
    @(posedge i_sys_clk);
    o_rx_pkt <= '{valid: 1'b1, pid: p, ep: e, ep_valid: v};
    @(posedge i_sys_clk);
    o_rx_pkt <= '{valid: 1'b0, pid: ~p, ep: ~e, ep_valid: ~v};
  endtask
endmodule

/* verif/usb_iface_frame_phy_regs_tb_top.sv */
/*
  Self-checking bench for the frame and transceiver register slice.
  Assumes the host model drives linestate and packet pulses.
*/
`timescale 1ns/10ps
module usb_iface_frame_phy_regs_tb_top;
  import ufp_pkg::*;
  logic i_sys_clk, i_rst_b, i_wr, i_rd, i_suspended;
  logic o_resume_req, o_pulldown_off, o_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_otg_mask;
  logic [1:0] line, o_linestate_filt;
  logic [2:0] o_xcvr_conf;
  logic [8:0] o_pwr_sig;
  ufp_rx_pkt_s rx_pkt;
  ufp_rx_port_s o_rx_port;
  int fails = 0;
  int checks_done = 0;

  ufp_frame_regs #(.EP_NUM(16)) ufp_frame_regs_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pkt(rx_pkt),
    .o_rx_port(o_rx_port), .i_linestate(line), .i_suspended(i_suspended),
    .o_linestate_filt(o_linestate_filt), .o_resume_req(o_resume_req),
    .o_xcvr_conf(o_xcvr_conf), .o_pulldown_off(o_pulldown_off),
    .o_otg_mask(o_otg_mask), .o_pwr_sig(o_pwr_sig), .o_irq(o_irq)
  );
  ufp_host_model ufp_host_model_i (
    .i_sys_clk(i_sys_clk), .o_linestate(line), .o_rx_pkt(rx_pkt)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk_reg(o_rdata, e);
  endtask
  // Bounds allow for the three-flop synchroniser ahead of the filter
  task automatic line_step(input int n, input logic [1:0] ls);
    int c;
    c = 0;
    ufp_host_model_i.set_line(ls);
    while (o_linestate_filt !== ls) begin
      @(posedge i_sys_clk);
      #1;
      c++;
      if (c > 40) begin
        fails++;
        results();
      end
    end
    chk_pin(9'(c >= (1 << n) + 2 && c <= (1 << n) + 8), 9'h001);
  endtask
  task automatic pkt_step(input logic [3:0] p, input logic [3:0] e, input logic v,
                          input logic [7:0] d);
    ufp_host_model_i.send_pkt(p, e, v);
    #1;
    chk_pin(9'(o_rx_port.valid), 9'(v));
    if (v) begin
      chk_pin(9'(o_rx_port.data), 9'(d));
      rd_chk(UFP_OFF_EP, {27'h0, 1'b1, e});
    end
    rd_chk(UFP_OFF_PID, {28'h0, p});
  endtask

  task automatic t_reset();
    for (int a = 'h28; a <= 'h40; a += 4) begin
      rd_chk(8'(a), UFP_RST_ZERO);
    end
  endtask
  task automatic t_regs();
    wr(UFP_OFF_SOF, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_SOF, 32'h0000_07FF);
    wr(UFP_OFF_SOF, 32'h0000_0523);
    rd_chk(UFP_OFF_SOF, 32'h0000_0523);
    wr(UFP_OFF_PID, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_PID, 32'h0000_0000);
    wr(UFP_OFF_EP, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_EP, 32'h0000_0000);
    wr(UFP_OFF_EP_MARK, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_EP_MARK, 32'h0000_FFFF);
    wr(UFP_OFF_PWR_SIG, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_PWR_SIG, 32'h0000_01FF);
    chk_pin(o_pwr_sig, 9'h1FF);
    wr(UFP_OFF_OTG_MASK, 32'hA5A5_5A5A);
    rd_chk(UFP_OFF_OTG_MASK, 32'hA5A5_5A5A);
    chk_reg(o_otg_mask, 32'hA5A5_5A5A);
    wr(8'h50, 32'hFFFF_FFFF);
    rd_chk(8'h50, 32'h0000_0000);
    wr(UFP_OFF_XCVR_CTRL, 32'hFFFF_FFFF);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0004_0FF0);
    chk_pin(9'(o_pulldown_off), 9'h001);
    chk_pin(9'(o_xcvr_conf), 9'h007);
    wr(UFP_OFF_XCVR_CTRL, 32'h0000_0050);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_0050);
    chk_pin(9'(o_pulldown_off), 9'h000);
    chk_pin(9'(o_xcvr_conf), 9'h005);
  endtask
  task automatic t_pkt();
    wr(UFP_OFF_EP_MARK, 32'h0000_0008);
    wr(UFP_OFF_IRQ_MASK, 32'h0000_0001);
    rd_chk(UFP_OFF_IRQ_STATUS, 32'h0000_0008);
    pkt_step(4'hA, 4'h3, 1'b1, 8'h13);
    chk_pin(9'(o_irq), 9'h001);
    rd_chk(UFP_OFF_IRQ_STATUS, 32'h0000_0001);
    @(posedge i_sys_clk);
    #1;
    chk_pin(9'(o_irq), 9'h000);
    wr(UFP_OFF_IRQ_MASK, 32'h0000_0000);
    pkt_step(4'h5, 4'h5, 1'b1, 8'h05);
    pkt_step(4'hC, 4'h3, 1'b0, 8'h00);
    chk_pin(9'(o_irq), 9'h000);
    rd_chk(UFP_OFF_IRQ_STATUS, 32'h0000_0001);
  endtask
  task automatic t_line();
    wr(UFP_OFF_XCVR_CTRL, 32'h0000_0480);
    i_suspended <= 1'b1;
    line_step(4, UFP_LS_K);
    @(posedge i_sys_clk);
    #1;
    chk_pin(9'(o_resume_req), 9'h001);
    @(posedge i_sys_clk);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_1480);
    wr(UFP_OFF_XCVR_CTRL, 32'h0000_0080);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_0080);
    line_step(0, 2'h1);
    line_step(0, UFP_LS_SE0);
    @(posedge i_sys_clk);
    #1;
    chk_pin(9'(o_resume_req), 9'h001);
    @(posedge i_sys_clk);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_2080);
    wr(UFP_OFF_XCVR_CTRL, 32'h0000_3080);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_2080);
    wr(UFP_OFF_XCVR_CTRL, 32'h0000_0000);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_0000);
    line_step(0, UFP_LS_K);
    @(posedge i_sys_clk);
    #1;
    chk_pin(9'(o_resume_req), 9'h000);
    @(posedge i_sys_clk);
    rd_chk(UFP_OFF_XCVR_CTRL, 32'h0000_0000);
    i_suspended <= 1'b0;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    i_rst_b = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_suspended = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_pkt();
    t_line();
    results();
  end
endmodule
